// File: design/ttu_pkg.sv
// Summary of operation
// - basic trigger trips when its input is at or above its trip level
// - basic trigger latches until an explicit clear request arrives
// - disable flag: 0 lets the trigger evaluate, 1 stops it tripping
// - boolean and standalone triggers trip on a 1 or 0 bit, latching
// - hysteresis trigger trips after the level holds for assert dwell
// - assert dwell of 0 trips in the same evaluation the level is met
// - non-latching hysteresis clears after release dwell below level
// - release dwell of 0 clears as soon as input drops below level
// - hold-mode selector: 1 latching with explicit clear, 0 self-clearing
// - each cell input has a presence flag, 1 connected, 0 not
// - cell inputs use a fixed zero-based index, 0 is first base cell
// - cell index 16 is the first cell of an attached expansion module
// - each thermistor input has a presence flag, 1 connected, 0 not
// - thermistor index is fixed, index 8 is first expansion thermistor
// - stack name held as four consecutive 8-character label words
// - ordinary fault requests orderly disconnect, optional auto reconnect
// - over/under fault requests fast disconnect, held until user clear
package ttu_pkg;
   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS     = 25;
   localparam int DWELL_UNIT_NS     = 1000000;
   localparam int DWELL_TICK_CYCLES = DWELL_UNIT_NS / CLK_PERIOD_NS;
   // ==========================================================
   // sizes
   localparam int VAL_W       = 16;
   localparam int DWELL_W     = 16;
   localparam int IDX_W       = 5;
   localparam int N_CELL      = 32;
   localparam int N_THERM     = 16;
   localparam int N_LVL       = 4;
   localparam int N_HYS       = 2;
   localparam int N_BOOL      = 2;
   localparam int N_NAME_REGS = 8;
   localparam logic [IDX_W-1:0] CELL_EXP_BASE  = 5'h10;
   localparam logic [IDX_W-1:0] THERM_EXP_BASE = 5'h08;
   localparam logic [IDX_W-1:0] THERM_LIMIT    = 5'h10;
   // ==========================================================
   // register offsets
   localparam logic [11:0] A_CTRL        = 12'h000;
   localparam logic [11:0] A_CLEAR       = 12'h004;
   localparam logic [11:0] A_STATUS      = 12'h008;
   localparam logic [11:0] A_CELL_PRES   = 12'h00c;
   localparam logic [11:0] A_THERM_PRES  = 12'h010;
   localparam logic [11:0] A_STACK_NAME_WORD_FIRST  = 12'h040;
   localparam logic [11:0] A_STACK_NAME_WORD_SECOND = 12'h048;
   localparam logic [11:0] A_STACK_NAME_WORD_THIRD  = 12'h050;
   localparam logic [11:0] A_STACK_NAME_WORD_FOURTH = 12'h058;
   localparam logic [11:0] A_LVL_BASE    = 12'h080;
   localparam logic [11:0] A_HYS_BASE    = 12'h0a0;
   localparam logic [11:0] A_BOOL_BASE   = 12'h0c0;
   localparam int          REG_STRIDE    = 4;
   localparam int          HYS_STRIDE    = 8;
   // ==========================================================
   // field positions
   localparam int CTRL_EXP_BIT    = 0;
   localparam int CTRL_AUTO_BIT   = 1;
   localparam int CLEAR_BIT       = 0;
   localparam int CFG_KIND_BIT    = 16;
   localparam int CFG_IDX_LSB     = 17;
   localparam int CFG_LATCH_BIT   = 30;
   localparam int CFG_DIS_BIT     = 31;
   localparam int BOOL_POL_BIT    = 0;
   localparam int DW_REL_LSB      = 16;
   localparam int ST_LVL_LSB      = 0;
   localparam int ST_HYS_LSB      = 4;
   localparam int ST_BOOL_LSB     = 8;
   localparam int ST_ORD_BIT      = 12;
   localparam int ST_FAST_BIT     = 13;
   // ==========================================================
   // reset values
   localparam logic [31:0] CFG_RST   = 32'h8000_0000;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   // ==========================================================
   // types
   typedef enum logic [1:0] {
      HYS_CLEAR   = 2'b01,
      HYS_TRIPPED = 2'b10
   } ttu_hys_state_t;
endpackage : ttu_pkg

// File: design/ttu_level_trig.sv
`timescale 1ns/1ps
`default_nettype none
module ttu_level_trig
   import ttu_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // control
   input  wire logic cond,
   input  wire logic disabled,
   input  wire logic clear,
   // result
   output logic      tripped
);
   logic tripped_q;
   logic tripped_d;

   // ==========================================================
   // latch, set wins over clear
   always_comb begin
      tripped_d = (tripped_q && !clear && !disabled)
                  || (cond && !disabled);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         tripped_q <= 1'b0;
      end else begin
         tripped_q <= tripped_d;
      end
   end

   assign tripped = tripped_q;
endmodule : ttu_level_trig
`default_nettype wire

// File: design/ttu_hyst_trig.sv
`timescale 1ns/1ps
`default_nettype none
module ttu_hyst_trig
   import ttu_pkg::*;
(
   // clock and reset
   input  wire logic               clk,
   input  wire logic               rst,
   // control
   input  wire logic               cond,
   input  wire logic               tick,
   input  wire logic [DWELL_W-1:0] dwell_assert,
   input  wire logic [DWELL_W-1:0] dwell_release,
   input  wire logic               latched,
   input  wire logic               disabled,
   input  wire logic               clear,
   // result
   output logic                    tripped
);
   ttu_hys_state_t     st_q;
   ttu_hys_state_t     st_d;
   logic [DWELL_W-1:0] cnt_q;
   logic [DWELL_W-1:0] cnt_d;
   logic [DWELL_W-1:0] cnt_inc;

   // ==========================================================
   // dwell state machine
   always_comb begin
      st_d    = st_q;
      cnt_d   = cnt_q;
      cnt_inc = cnt_q + 16'h0001;
      unique case (st_q)
         HYS_CLEAR: begin
            if (disabled || !cond) begin
               cnt_d = '0;
            end else if (dwell_assert == '0) begin
               st_d  = HYS_TRIPPED;
               cnt_d = '0;
            end else if (tick) begin
               cnt_d = cnt_inc;
               if (cnt_inc >= dwell_assert) begin
                  st_d  = HYS_TRIPPED;
                  cnt_d = '0;
               end
            end
         end
         HYS_TRIPPED: begin
            if (disabled || clear) begin
               st_d  = HYS_CLEAR;
               cnt_d = '0;
            end else if (latched || cond) begin
               cnt_d = '0;
            end else if (dwell_release == '0) begin
               st_d  = HYS_CLEAR;
               cnt_d = '0;
            end else if (tick) begin
               cnt_d = cnt_inc;
               if (cnt_inc >= dwell_release) begin
                  st_d  = HYS_CLEAR;
                  cnt_d = '0;
               end
            end
         end
         default: begin
            st_d  = HYS_CLEAR;
            cnt_d = '0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q  <= HYS_CLEAR;
         cnt_q <= '0;
      end else begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
      end
   end

   assign tripped = (st_q == HYS_TRIPPED);
endmodule : ttu_hyst_trig
`default_nettype wire

// File: design/ttu_top.sv
`timescale 1ns/1ps
`default_nettype none
module ttu_top
   import ttu_pkg::*;
#(
   parameter int TICK_CYCLES = DWELL_TICK_CYCLES
)(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // ahb-lite slave
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic [31:0]            hrdata,
   // measurement front end
   input  wire logic              meas_valid,
   input  wire logic              meas_kind,
   input  wire logic [IDX_W-1:0]  meas_index,
   input  wire logic [VAL_W-1:0]  meas_value,
   // boolean trigger pins
   input  wire logic [N_BOOL-1:0] bool_pin,
   // trip and disconnect requests
   output logic [N_LVL-1:0]       lvl_tripped,
   output logic [N_HYS-1:0]       hys_tripped,
   output logic [N_BOOL-1:0]      bool_tripped,
   output logic                   disconnect_orderly,
   output logic                   disconnect_fast
);
   // ==========================================================
   // helpers
   function automatic logic chan_ok(input logic           kind,
                                    input logic [IDX_W-1:0] idx,
                                    input logic [31:0]    cpres,
                                    input logic [15:0]    tpres,
                                    input logic           exp);
      logic ok;
      ok = 1'b0;
      if (!kind) begin
         ok = cpres[idx] && (idx < CELL_EXP_BASE || exp);
      end else if (idx < THERM_LIMIT) begin
         ok = tpres[idx[3:0]] && (idx < THERM_EXP_BASE || exp);
      end
      return ok;
   endfunction : chan_ok

   function automatic logic cfg_hit(input logic [31:0]      cfg,
                                    input logic             kind,
                                    input logic [IDX_W-1:0] idx);
      return cfg[CFG_KIND_BIT] == kind
             && cfg[CFG_IDX_LSB +: IDX_W] == idx;
   endfunction : cfg_hit

   // ==========================================================
   // register state
   logic [31:0] ctrl_q, ctrl_d;
   logic [31:0] cpres_q, cpres_d;
   logic [15:0] tpres_q, tpres_d;
   logic [31:0] name_q [N_NAME_REGS];
   logic [31:0] name_d [N_NAME_REGS];
   logic [31:0] lvl_cfg_q [N_LVL];
   logic [31:0] lvl_cfg_d [N_LVL];
   logic [31:0] hys_cfg_q [N_HYS];
   logic [31:0] hys_cfg_d [N_HYS];
   logic [31:0] hys_dw_q [N_HYS];
   logic [31:0] hys_dw_d [N_HYS];
   logic [31:0] bool_cfg_q [N_BOOL];
   logic [31:0] bool_cfg_d [N_BOOL];
   logic        clear_q, clear_d;
   logic        wr_pend_q, wr_pend_d;
   logic [11:0] wr_addr_q, wr_addr_d;
   logic [31:0] hrdata_q, hrdata_d;
   logic [31:0] status;
   logic        addr_ok;
   logic [11:0] rd_addr;

   // ==========================================================
   // bus slave and register file
   always_comb begin
      ctrl_d     = ctrl_q;
      cpres_d    = cpres_q;
      tpres_d    = tpres_q;
      name_d     = name_q;
      lvl_cfg_d  = lvl_cfg_q;
      hys_cfg_d  = hys_cfg_q;
      hys_dw_d   = hys_dw_q;
      bool_cfg_d = bool_cfg_q;
      clear_d    = 1'b0;
      hrdata_d   = hrdata_q;
      addr_ok    = hsel && hready && htrans[1];
      wr_pend_d  = addr_ok && hwrite;
      wr_addr_d  = addr_ok ? haddr[11:0] : wr_addr_q;
      rd_addr    = haddr[11:0];
      if (wr_pend_q) begin
         if (wr_addr_q == A_CTRL) begin
            ctrl_d = hwdata;
         end
         if (wr_addr_q == A_CLEAR) begin
            clear_d = hwdata[CLEAR_BIT];
         end
         if (wr_addr_q == A_CELL_PRES) begin
            cpres_d = hwdata;
         end
         if (wr_addr_q == A_THERM_PRES) begin
            tpres_d = hwdata[15:0];
         end
         for (int i = 0; i < N_NAME_REGS; i++) begin
            if (wr_addr_q == A_STACK_NAME_WORD_FIRST
                             + 12'(i * REG_STRIDE)) begin
               name_d[i] = hwdata;
            end
         end
         for (int i = 0; i < N_LVL; i++) begin
            if (wr_addr_q == A_LVL_BASE + 12'(i * REG_STRIDE)) begin
               lvl_cfg_d[i] = hwdata;
            end
         end
         for (int i = 0; i < N_HYS; i++) begin
            if (wr_addr_q == A_HYS_BASE + 12'(i * HYS_STRIDE)) begin
               hys_cfg_d[i] = hwdata;
            end
            if (wr_addr_q == A_HYS_BASE + 12'(i * HYS_STRIDE)
                             + 12'(REG_STRIDE)) begin
               hys_dw_d[i] = hwdata;
            end
         end
         for (int i = 0; i < N_BOOL; i++) begin
            if (wr_addr_q == A_BOOL_BASE + 12'(i * REG_STRIDE)) begin
               bool_cfg_d[i] = hwdata;
            end
         end
      end
      if (addr_ok && !hwrite) begin
         hrdata_d = WORD_ZERO;
         if (rd_addr == A_CTRL) begin
            hrdata_d = ctrl_q;
         end
         if (rd_addr == A_STATUS) begin
            hrdata_d = status;
         end
         if (rd_addr == A_CELL_PRES) begin
            hrdata_d = cpres_q;
         end
         if (rd_addr == A_THERM_PRES) begin
            hrdata_d = {16'h0000, tpres_q};
         end
         for (int i = 0; i < N_NAME_REGS; i++) begin
            if (rd_addr == A_STACK_NAME_WORD_FIRST
                           + 12'(i * REG_STRIDE)) begin
               hrdata_d = name_q[i];
            end
         end
         for (int i = 0; i < N_LVL; i++) begin
            if (rd_addr == A_LVL_BASE + 12'(i * REG_STRIDE)) begin
               hrdata_d = lvl_cfg_q[i];
            end
         end
         for (int i = 0; i < N_HYS; i++) begin
            if (rd_addr == A_HYS_BASE + 12'(i * HYS_STRIDE)) begin
               hrdata_d = hys_cfg_q[i];
            end
            if (rd_addr == A_HYS_BASE + 12'(i * HYS_STRIDE)
                           + 12'(REG_STRIDE)) begin
               hrdata_d = hys_dw_q[i];
            end
         end
         for (int i = 0; i < N_BOOL; i++) begin
            if (rd_addr == A_BOOL_BASE + 12'(i * REG_STRIDE)) begin
               hrdata_d = bool_cfg_q[i];
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_q     <= WORD_ZERO;
         cpres_q    <= WORD_ZERO;
         tpres_q    <= 16'h0000;
         name_q     <= '{default: WORD_ZERO};
         lvl_cfg_q  <= '{default: CFG_RST};
         hys_cfg_q  <= '{default: CFG_RST};
         hys_dw_q   <= '{default: WORD_ZERO};
         bool_cfg_q <= '{default: CFG_RST};
         clear_q    <= 1'b0;
         wr_pend_q  <= 1'b0;
         wr_addr_q  <= 12'h000;
         hrdata_q   <= WORD_ZERO;
      end else begin
         ctrl_q     <= ctrl_d;
         cpres_q    <= cpres_d;
         tpres_q    <= tpres_d;
         name_q     <= name_d;
         lvl_cfg_q  <= lvl_cfg_d;
         hys_cfg_q  <= hys_cfg_d;
         hys_dw_q   <= hys_dw_d;
         bool_cfg_q <= bool_cfg_d;
         clear_q    <= clear_d;
         wr_pend_q  <= wr_pend_d;
         wr_addr_q  <= wr_addr_d;
         hrdata_q   <= hrdata_d;
      end
   end

   // ==========================================================
   // dwell tick divider and pin synchroniser
   logic [31:0]       tick_cnt_q, tick_cnt_d;
   logic              tick_q, tick_d;
   logic [N_BOOL-1:0] pin_s1_q, pin_s2_q;

   always_comb begin
      tick_d     = 1'b0;
      tick_cnt_d = tick_cnt_q + 32'h0000_0001;
      if (tick_cnt_q >= 32'(TICK_CYCLES - 1)) begin
         tick_cnt_d = 32'h0000_0000;
         tick_d     = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         tick_cnt_q <= 32'h0000_0000;
         tick_q     <= 1'b0;
         pin_s1_q   <= '0;
         pin_s2_q   <= '0;
      end else begin
         tick_cnt_q <= tick_cnt_d;
         tick_q     <= tick_d;
         pin_s1_q   <= bool_pin;
         pin_s2_q   <= pin_s1_q;
      end
   end

   // ==========================================================
   // level conditions from the measurement stream
   logic [N_LVL-1:0]  lvl_cond_q, lvl_cond_d, lvl_cond;
   logic [N_HYS-1:0]  hys_cond_q, hys_cond_d, hys_cond;
   logic [N_BOOL-1:0] bool_cond;

   always_comb begin
      lvl_cond_d = lvl_cond_q;
      hys_cond_d = hys_cond_q;
      for (int i = 0; i < N_LVL; i++) begin
         if (meas_valid && cfg_hit(lvl_cfg_q[i], meas_kind, meas_index)) begin
            lvl_cond_d[i] = meas_value >= lvl_cfg_q[i][VAL_W-1:0];
         end
         lvl_cond[i] = lvl_cond_q[i]
                       && chan_ok(lvl_cfg_q[i][CFG_KIND_BIT],
                                  lvl_cfg_q[i][CFG_IDX_LSB +: IDX_W],
                                  cpres_q, tpres_q,
                                  ctrl_q[CTRL_EXP_BIT]);
      end
      for (int i = 0; i < N_HYS; i++) begin
         if (meas_valid && cfg_hit(hys_cfg_q[i], meas_kind, meas_index)) begin
            hys_cond_d[i] = meas_value >= hys_cfg_q[i][VAL_W-1:0];
         end
         hys_cond[i] = hys_cond_q[i]
                       && chan_ok(hys_cfg_q[i][CFG_KIND_BIT],
                                  hys_cfg_q[i][CFG_IDX_LSB +: IDX_W],
                                  cpres_q, tpres_q,
                                  ctrl_q[CTRL_EXP_BIT]);
      end
      for (int i = 0; i < N_BOOL; i++) begin
         bool_cond[i] = pin_s2_q[i] == bool_cfg_q[i][BOOL_POL_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         lvl_cond_q <= '0;
         hys_cond_q <= '0;
      end else begin
         lvl_cond_q <= lvl_cond_d;
         hys_cond_q <= hys_cond_d;
      end
   end

   // ==========================================================
   // trigger bank
   for (genvar g = 0; g < N_LVL; g++) begin : g_lvl
      ttu_level_trig u_trig (
         .clk      (clk),
         .rst      (rst),
         .cond     (lvl_cond[g]),
         .disabled (lvl_cfg_q[g][CFG_DIS_BIT]),
         .clear    (clear_q),
         .tripped  (lvl_tripped[g])
      );
   end
   for (genvar g = 0; g < N_BOOL; g++) begin : g_bool
      ttu_level_trig u_trig (
         .clk      (clk),
         .rst      (rst),
         .cond     (bool_cond[g]),
         .disabled (bool_cfg_q[g][CFG_DIS_BIT]),
         .clear    (clear_q),
         .tripped  (bool_tripped[g])
      );
   end
   for (genvar g = 0; g < N_HYS; g++) begin : g_hys
      ttu_hyst_trig u_trig (
         .clk           (clk),
         .rst           (rst),
         .cond          (hys_cond[g]),
         .tick          (tick_q),
         .dwell_assert  (hys_dw_q[g][DWELL_W-1:0]),
         .dwell_release (hys_dw_q[g][DW_REL_LSB +: DWELL_W]),
         .latched       (hys_cfg_q[g][CFG_LATCH_BIT]),
         .disabled      (hys_cfg_q[g][CFG_DIS_BIT]),
         .clear         (clear_q),
         .tripped       (hys_tripped[g])
      );
   end

   // ==========================================================
   // disconnect requests
   logic ord_q, ord_d;
   logic fast_q, fast_d;

   always_comb begin
      if (ctrl_q[CTRL_AUTO_BIT]) begin
         ord_d = |hys_tripped;
      end else begin
         ord_d = !clear_q && (ord_q || (|hys_tripped));
      end
      fast_d = !clear_q
               && (fast_q || (|lvl_tripped) || (|bool_tripped));
      status = WORD_ZERO;
      status[ST_LVL_LSB +: N_LVL]   = lvl_tripped;
      status[ST_HYS_LSB +: N_HYS]   = hys_tripped;
      status[ST_BOOL_LSB +: N_BOOL] = bool_tripped;
      status[ST_ORD_BIT]            = ord_q;
      status[ST_FAST_BIT]           = fast_q;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ord_q  <= 1'b0;
         fast_q <= 1'b0;
      end else begin
         ord_q  <= ord_d;
         fast_q <= fast_d;
      end
   end

   assign hreadyout          = 1'b1;
   assign hresp              = 1'b0;
   assign hrdata             = hrdata_q;
   assign disconnect_orderly = ord_q;
   assign disconnect_fast    = fast_q;
endmodule : ttu_top
`default_nettype wire

// File: sim/ttu_top_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ttu_top_checker
   import ttu_pkg::*;
#(
   parameter int TICK_CYCLES = 8
)(
   // bus
   input wire logic              clk,
   input wire logic              rst,
   input wire logic              hsel,
   input wire logic [1:0]        htrans,
   input wire logic              hwrite,
   input wire logic              hready,
   // results
   input wire logic              meas_valid,
   input wire logic [N_LVL-1:0]  lvl_tripped,
   input wire logic [N_HYS-1:0]  hys_tripped,
   input wire logic [N_BOOL-1:0] bool_tripped,
   input wire logic              disconnect_orderly,
   input wire logic              disconnect_fast
);
   // =====
   // bus quiet time and trip summaries
   logic [2:0] quiet_q, quiet_d;
   logic       seen_q, seen_d;
   logic       take, any_f, any_h;
   always_comb begin
      take = hsel && hready && htrans[1];
      quiet_d = take ? 3'h0 : quiet_q + {2'h0, quiet_q != 3'h7};
      seen_d = seen_q || (take && hwrite);
      any_f = |{lvl_tripped, bool_tripped};
      any_h = |hys_tripped;
   end
   always_ff @(posedge clk) begin
      quiet_q <= rst ? 3'h0 : quiet_d;
      seen_q <= rst ? 1'b0 : seen_d;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_lvl_latch_hold: assert property (
      quiet_q == 3'h7 |-> ($past(lvl_tripped) & ~lvl_tripped) == '0)
      else $error("basic trip dropped without clear");
   a_bool_latch_hold: assert property (
      quiet_q == 3'h7 |-> ($past(bool_tripped) & ~bool_tripped) == '0)
      else $error("boolean trip dropped without clear");
   a_fast_stays_held: assert property (
      quiet_q == 3'h7 |-> !$fell(disconnect_fast))
      else $error("fast disconnect dropped without clear");
   a_fast_follows_trip: assert property (
      $rose(any_f) |-> ##1 disconnect_fast)
      else $error("fast disconnect missing after trip");
   a_orderly_follows_hys: assert property (
      $rose(any_h) |-> ##[1:2] disconnect_orderly)
      else $error("orderly disconnect missing after trip");
   a_orderly_has_cause: assert property (
      $rose(disconnect_orderly) |-> any_h || $past(any_h))
      else $error("orderly disconnect without trip");
   a_lvl_after_meas: assert property (
      $rose(lvl_tripped[0]) |-> $past(meas_valid, 2))
      else $error("basic trip without measurement");
   a_cfg_reset_quiet: assert property (
      !seen_q |-> !any_f && !any_h && !disconnect_orderly && !disconnect_fast)
      else $error("trip before any configuration");
endmodule : ttu_top_checker
bind ttu_top ttu_top_checker #(.TICK_CYCLES(TICK_CYCLES)) ttu_top_checker_i (
   .clk, .rst, .hsel, .htrans, .hwrite, .hready, .meas_valid, .lvl_tripped,
   .hys_tripped, .bool_tripped, .disconnect_orderly, .disconnect_fast);
`default_nettype wire

// File: sim/ttu_fe_model.sv
`timescale 1ns/1ps
`default_nettype none
module ttu_fe_model
   import ttu_pkg::*;
(
   // measurement front end
   input  wire logic        clk,
   output logic             meas_valid,
   output logic             meas_kind,
   output logic [IDX_W-1:0] meas_index,
   output logic [VAL_W-1:0] meas_value
);
   // =====
   // one-cycle measurement, value scrambled once released
   initial begin
      {meas_valid, meas_kind, meas_index, meas_value} = '0;
   end
   task send(input logic k, input logic [4:0] i, input logic [15:0] v);
      meas_valid <= 1'b1;
      meas_kind <= k;
      meas_index <= i;
      meas_value <= v;
      @(posedge clk);
      meas_valid <= 1'b0;
      meas_value <= ~v;
      @(posedge clk);
   endtask : send
endmodule : ttu_fe_model
`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_count++; \
   $display("wrong value at %0t: %h not %h", $time, a, b); end end
module tb;
   import ttu_pkg::*;
   localparam int TK = 8;
   logic              clk, rst, hwrite, hreadyout, hresp, rd_dp;
   logic [1:0]        htrans;
   logic [31:0]       haddr, hwdata, hrdata, exp_w;
   logic              meas_valid, meas_kind, ord, fst;
   logic              disconnect_orderly, disconnect_fast;
   logic [IDX_W-1:0]  meas_index;
   logic [VAL_W-1:0]  meas_value, thr;
   logic [N_LVL-1:0]  lvl_tripped, lv;
   logic [N_HYS-1:0]  hys_tripped, hy;
   logic [N_BOOL-1:0] bool_tripped, bool_pin, bl;
   logic [31:0]       expq[$], nm[N_NAME_REGS];
   int                err_count, compares;
   ttu_top #(.TICK_CYCLES(TK)) ttu_top_i (.clk, .rst, .hsel(1'b1), .haddr,
      .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
      .hreadyout, .hresp, .hrdata, .meas_valid, .meas_kind, .meas_index,
      .meas_value, .bool_pin, .lvl_tripped, .hys_tripped, .bool_tripped,
      .disconnect_orderly, .disconnect_fast);
   ttu_fe_model ttu_fe_model_i (.clk, .meas_valid, .meas_kind, .meas_index,
      .meas_value);
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // =====
   // bus master and status checks
   task wrap_up;
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : wrap_up
   task wt;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 40);
      if (n >= 40) begin
         err_count++;
         wrap_up();
      end
   endtask : wt
   task xf(input logic w, input logic [11:0] a, input logic [31:0] d);
      htrans <= 2'h2;
      haddr <= {20'h0, a};
      hwrite <= w;
      wt();
      htrans <= 2'h0;
      hwdata <= d;
      wt();
   endtask : xf
   task rd(input logic [11:0] a, input logic [31:0] e);
      expq.push_back(e);
      xf(1'b0, a, 32'h0);
   endtask : rd
   task ck(input int n);
      repeat (n) @(posedge clk);
      rd(A_STATUS, {18'h0, fst, ord, 2'h0, bl, 2'h0, hy, lv});
   endtask : ck
   task ms(input logic k, input logic [4:0] i, input logic [15:0] v);
      ttu_fe_model_i.send(k, i, v);
   endtask : ms
   function logic [31:0] cf(input logic d, l, k, input logic [4:0] i);
      return {d, l, 8'h0, i, k, thr};
   endfunction : cf
   always @(posedge clk) begin
      if (rd_dp) begin
         exp_w = expq.pop_front();
         `CHK(hrdata, exp_w)
         `CHK(hresp, 1'b0)
      end
      rd_dp <= htrans[1] && !hwrite && hreadyout && !rst;
   end
   initial begin
      {rst, htrans, haddr, hwrite, hwdata} = {1'b1, 67'h0};
      {lv, hy, bl, ord, fst, err_count, compares} = '0;
      bool_pin = 2'h2;
      void'($urandom(32'hfed9c200));
      thr = {8'h08, 8'($urandom())};
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(A_LVL_BASE, CFG_RST);
      rd(A_CELL_PRES, WORD_ZERO);
      rd(12'h100, WORD_ZERO);
      for (int i = 0; i < N_NAME_REGS; i++) begin
         nm[i] = $urandom();
         xf(1'b1, A_STACK_NAME_WORD_FIRST + 12'(4 * i), nm[i]);
      end
      for (int i = 0; i < N_NAME_REGS; i++)
         rd(A_STACK_NAME_WORD_FIRST + 12'(4 * i), nm[i]);
      xf(1'b1, A_CTRL, 32'h2);
      xf(1'b1, A_CELL_PRES, 32'h0001_0018);
      xf(1'b1, A_LVL_BASE, cf(0, 0, 0, 5'h03));
      xf(1'b1, A_LVL_BASE + 12'h4, cf(1, 0, 0, 5'h03));
      xf(1'b1, A_LVL_BASE + 12'h8, cf(0, 0, 1, 5'h08));
      xf(1'b1, A_LVL_BASE + 12'hc, cf(0, 0, 0, 5'h10));
      ms(1'b0, 5'h03, thr - 16'h1);
      ck(3);
      ms(1'b0, 5'h03, thr);
      {lv, fst} = 5'h3;
      ck(3);
      ms(1'b0, 5'h03, 16'h0);
      ms(1'b1, 5'h08, thr);
      ms(1'b0, 5'h10, thr);
      ck(3);
      xf(1'b1, A_CTRL, 32'h3);
      xf(1'b1, A_THERM_PRES, 32'h100);
      ms(1'b1, 5'h08, thr);
      ms(1'b0, 5'h10, thr);
      lv = 4'hd;
      ck(3);
      ms(1'b1, 5'h08, 16'h0);
      ms(1'b0, 5'h10, 16'h0);
      xf(1'b1, A_CLEAR, 32'h1);
      {lv, fst} = 5'h0;
      ck(3);
      xf(1'b1, A_HYS_BASE, cf(0, 0, 0, 5'h04));
      xf(1'b1, A_HYS_BASE + 12'h4, 32'h0002_0002);
      xf(1'b1, A_HYS_BASE + 12'h8, cf(0, 0, 0, 5'h04));
      xf(1'b1, A_HYS_BASE + 12'hc, 32'h0);
      for (int p = 0; p < 2; p++) begin
         ms(1'b0, 5'h04, thr);
         {hy, ord} = 3'h5;
         ck(3);
         hy = 2'h3;
         ck(3 * TK);
         ms(1'b0, 5'h04, 16'h0);
         hy = 2'h1;
         ck(p == 0 ? 3 : 3 * TK);
         if (p == 0) begin
            {hy, ord} = 3'h0;
            ck(3 * TK);
            xf(1'b1, A_HYS_BASE, cf(0, 1, 0, 5'h04));
         end
      end
      xf(1'b1, A_CLEAR, 32'h1);
      {hy, ord} = 3'h0;
      ck(3);
      xf(1'b1, A_BOOL_BASE, 32'h1);
      xf(1'b1, A_BOOL_BASE + 12'h4, 32'h0);
      ck(3);
      bool_pin <= 2'h1;
      {bl, fst} = 3'h7;
      ck(6);
      bool_pin <= 2'h2;
      ck(6);
      xf(1'b1, A_CLEAR, 32'h1);
      {bl, fst} = 3'h0;
      ck(3);
      repeat (2) @(posedge clk);
      wrap_up();
   end
endmodule : tb
`default_nettype wire
